// ---- bench/spp_master.sv ----
// Serial bus master model driving the port's link pins
`timescale 1ns/1ps
module spp_master (
	// Link pins
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic sdo
);
	// A real rising edge of the select clears the shifter before the first frame
	initial begin
		sclk = 1'b0;
		cs_n = 1'b0;
		din = 1'b0;
		#2;
		cs_n = 1'b1;
	end

	// Shifts nbits MSB first; clock idles at cpol and stands still between frames
	task automatic xfer(input logic [23:0] tx, input int nbits, input logic cpol,
		input logic sel, output logic [15:0] rx);
		// Clock settles to its idle level while deselected, so no edge counts
		sclk = cpol;
		#20;
		cs_n = !sel;
		#10;
		for (int i = 0; i < nbits; i++) begin
			din = tx[23-i];
			if (!cpol) sclk = 1'b1;
			#3;
			rx = {rx[14:0], sdo};
			sclk = 1'b0;
			#3;
			if (cpol) sclk = 1'b1;
			if (i % 8 == 7) #200;
		end
		#3;
		cs_n = 1'b1;
		din = !din;
		// Select stays high long enough for the core to take the last byte
		#200;
	endtask : xfer
endmodule : spp_master

// ---- bench/spp_top_properties.sv ----
// Concurrent checks on the serial control port pins
`timescale 1ns/1ps
module spp_top_properties
	import spp_pkg::*;
#(
	parameter int DAC_CHANNELS = 8,
	parameter int DATA_BITS = 12
)
(
	// Watched top ports
	input wire logic clock,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic dout_oe,
	input wire logic eoc_n,
	input wire logic start_pin_enabled,
	input wire logic dac_load_n,
	input wire logic dac_wake_select,
	input wire logic [DAC_CHANNELS*DATA_BITS-1:0] dac_codes,
	input wire logic dac_pull_ref,
	input wire logic dac_powered
);
	// ==========================================================
	// Sequences
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	sequence load_held;
		dac_load_n[*5];
	endsequence
	sequence conv_done;
		##225 $fell(eoc_n);
	endsequence

	// ==========================================================
	// Assertions
	oe_tracks_cs_a: assert property (dout_oe == !cs_n)
		else $error("output enable not tracking select");
	conv_len_a: assert property ($rose(eoc_n) |-> conv_done)
		else $error("conversion length wrong");
	result_wait_a: assert property ($fell(eoc_n) |-> $past(eoc_n, 225))
		else $error("end of conversion too early");
	eoc_stays_a: assert property ((!start_pin_enabled && cs_n && !eoc_n)[*8] |=> !eoc_n)
		else $error("disabled start pin started a conversion");
	load_power_a: assert property ((!dac_load_n)[*5] |-> dac_powered)
		else $error("load did not power the outputs");
	load_hold_a: assert property (load_held |=> $stable(dac_codes))
		else $error("codes moved without load");
	pull_follow_a: assert property ((!dac_powered && $stable(dac_wake_select))[*5]
		|-> dac_pull_ref == dac_wake_select) else $error("wake pull not following pin");
	pull_frozen_a: assert property (dac_powered |=> $stable(dac_pull_ref) && dac_powered)
		else $error("wake state changed after power up");
endmodule : spp_top_properties

bind spp_top spp_top_properties #(.DAC_CHANNELS(DAC_CHANNELS), .DATA_BITS(DATA_BITS))
	i_spp_top_properties (.clock(clock), .rst_n(rst_n), .cs_n(cs_n), .dout_oe(dout_oe),
	.eoc_n(eoc_n), .start_pin_enabled(start_pin_enabled), .dac_load_n(dac_load_n),
	.dac_wake_select(dac_wake_select), .dac_codes(dac_codes), .dac_pull_ref(dac_pull_ref),
	.dac_powered(dac_powered));

// ---- bench/spp_top_tb.sv ----
// Self-checking bench for the serial control port
`timescale 1ns/1ps
module spp_top_tb;
	import spp_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b1;
	logic convert_start_n = 1'b1;
	logic [11:0] adc_sample = 12'h000;
	logic dac_load_n = 1'b1;
	logic dac_wake_select = 1'b1;
	logic sclk, cs_n, din, dout, dout_oe, eoc_n, start_pin_enabled, dac_pull_ref, dac_powered;
	logic [95:0] dac_codes;
	logic [15:0] rx;
	int errors = 0;
	int comparisons = 0;
	int cycles = 0;
	wire sdo = dout_oe ? dout : 1'bz;

	always #20 clock = !clock;

	spp_master i_spp_master (.sclk(sclk), .cs_n(cs_n), .din(din), .sdo(sdo));
	spp_top i_spp_top (.clock(clock), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
		.dout(dout), .dout_oe(dout_oe), .convert_start_n(convert_start_n),
		.adc_sample(adc_sample), .eoc_n(eoc_n), .start_pin_enabled(start_pin_enabled),
		.dac_load_n(dac_load_n), .dac_wake_select(dac_wake_select), .dac_codes(dac_codes),
		.dac_pull_ref(dac_pull_ref), .dac_powered(dac_powered));

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic wait_eoc;
		for (int n = 0; n < 300 && eoc_n !== 1'b0; n++) @(negedge clock);
	endtask : wait_eoc

	task automatic t_reset;
		check("eoc", 16'h1, eoc_n);
		check("pin enable", 16'h0, start_pin_enabled);
		check("oe idle", 16'h0, dout_oe);
		check("codes", 16'h0, dac_codes[15:0]);
		$display("reset done");
	endtask : t_reset

	// Dropped partial byte, conversion, readout in the falling-edge modes
	task automatic t_conv;
		adc_sample = 12'ha5c;
		i_spp_master.xfer(24'h100000, 4, 1'b0, 1'b1, rx);
		i_spp_master.xfer(24'h800000, 8, 1'b0, 1'b1, rx);
		wait_eoc();
		check("eoc done", 16'h0, eoc_n);
		for (int m = 0; m < 3; m++) begin
			i_spp_master.xfer({2'h1, 2'(m), 20'h00000}, 8, 1'b0, 1'b1, rx);
			i_spp_master.xfer(24'h000000, 24, 1'b0, 1'b1, rx);
			check("result", 16'h0a5c, rx);
		end
		i_spp_master.xfer(24'h800000, 8, 1'b0, 1'b0, rx);
		repeat (10) @(negedge clock);
		check("deselected", 16'h0, eoc_n);
		check("oe off", 16'h0, dout_oe);
		convert_start_n = 1'b0;
		repeat (4) @(negedge clock);
		convert_start_n = 1'b1;
		repeat (10) @(negedge clock);
		check("pin off", 16'h0, eoc_n);
		$display("conversion done");
	endtask : t_conv

	// Start pin enabled, readout on rising edges
	task automatic t_mode11;
		adc_sample = 12'h3c7;
		i_spp_master.xfer(24'h780000, 8, 1'b0, 1'b1, rx);
		repeat (10) @(negedge clock);
		check("pin on", 16'h1, start_pin_enabled);
		convert_start_n = 1'b0;
		repeat (6) @(negedge clock);
		convert_start_n = 1'b1;
		check("busy", 16'h1, eoc_n);
		wait_eoc();
		i_spp_master.xfer(24'h000000, 24, 1'b1, 1'b1, rx);
		check("rise result", 16'h03c7, rx);
		$display("mode 11 done");
	endtask : t_mode11

	task automatic t_dac;
		repeat (6) @(negedge clock);
		check("wake ref", 16'h1, dac_pull_ref);
		dac_wake_select = 1'b0;
		i_spp_master.xfer(24'h1029a3, 24, 1'b0, 1'b1, rx);
		repeat (10) @(negedge clock);
		check("held", 16'h0, dac_codes[35:24]);
		check("wake gnd", 16'h0, dac_pull_ref);
		dac_load_n = 1'b0;
		repeat (5) @(negedge clock);
		check("loaded", 16'h09a3, dac_codes[35:24]);
		check("powered", 16'h1, dac_powered);
		i_spp_master.xfer(24'h102456, 24, 1'b0, 1'b1, rx);
		repeat (6) @(negedge clock);
		check("transparent", 16'h0456, dac_codes[35:24]);
		dac_load_n = 1'b1;
		dac_wake_select = 1'b1;
		repeat (6) @(negedge clock);
		check("frozen", 16'h0, dac_pull_ref);
		$display("dac done");
	endtask : t_dac

	task automatic print_verdict;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict

	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			print_verdict();
		end
	end

	// A real falling edge of reset clears the link-side flops as well
	initial begin
		#1;
		rst_n = 1'b0;
		repeat (2) @(negedge clock);
		rst_n = 1'b1;
		repeat (4) @(negedge clock);
		t_reset();
		t_conv();
		t_mode11();
		t_dac();
		print_verdict();
	end
endmodule : spp_top_tb

// ---- core/spp_link.sv ----
// Serial-clock domain shifter: samples input, drives output, reports bytes
`timescale 1ns/1ps
module spp_link
	import spp_pkg::*;
(
	// Reset
	input wire logic rst_n,
	// Serial pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	output logic dout,
	output logic dout_oe,
	// Control side
	spp_link_if.link lnk
);

	// ==========================================================
	// Frame state, cleared while the chip select is high
	logic [4:0] bit_cnt;
	logic [7:0] shreg;
	logic dout_f;
	logic dout_r;
	logic [4:0] next_bit_cnt;
	logic [7:0] next_shreg;
	logic next_dout_f;
	logic next_dout_r;
	logic [1:0] mode_s1;
	logic [1:0] mode_s2;

	always_comb begin
		next_bit_cnt = (bit_cnt == FRAME_CNT_MAX) ? bit_cnt : 5'(bit_cnt + 5'h01);
		next_shreg = {shreg[6:0], din}; // [R01] [R10]
		next_dout_f = dout_f;
		if (bit_cnt >= TX_FIRST_FALL && bit_cnt <= TX_LAST_FALL) begin
			next_dout_f = lnk.tx_word[4'(TX_LAST_FALL - bit_cnt)]; // [R02]
		end
		next_dout_r = dout_r;
		if (bit_cnt >= TX_FIRST_RISE && bit_cnt <= TX_LAST_RISE) begin
			next_dout_r = lnk.tx_word[4'(TX_LAST_RISE - bit_cnt)]; // [R03]
		end
	end

	// Chip select high returns the shifter to idle and drops partial bytes
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			bit_cnt <= 5'h00; // [R12] [R05]
			shreg <= 8'h00;
			dout_f <= 1'b0;
		end else begin
			bit_cnt <= next_bit_cnt;
			shreg <= next_shreg;
			dout_f <= next_dout_f;
		end
	end

	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			dout_r <= 1'b0;
		end else begin
			dout_r <= next_dout_r;
		end
	end

	// ==========================================================
	// Byte hand-off by toggle, and clock mode synchroniser
	logic [7:0] next_rx_byte;
	logic [1:0] next_rx_index;
	logic next_rx_toggle;

	always_comb begin
		next_rx_byte = lnk.rx_byte;
		next_rx_index = lnk.rx_index;
		next_rx_toggle = lnk.rx_toggle;
		if (!cs_n && bit_cnt[2:0] == 3'h7 && bit_cnt[4:3] != 2'h3) begin
			next_rx_byte = next_shreg;
			next_rx_index = bit_cnt[4:3];
			next_rx_toggle = !lnk.rx_toggle;
		end
	end

	always_ff @(negedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			lnk.rx_byte <= 8'h00;
			lnk.rx_index <= 2'h0;
			lnk.rx_toggle <= 1'b0;
			mode_s1 <= CLK_MODE_RST;
			mode_s2 <= CLK_MODE_RST;
		end else begin
			lnk.rx_byte <= next_rx_byte;
			lnk.rx_index <= next_rx_index;
			lnk.rx_toggle <= next_rx_toggle;
			mode_s1 <= lnk.clk_mode;
			mode_s2 <= mode_s1;
		end
	end

	// ==========================================================
	// Output pin: edge choice by mode, released while deselected
	assign dout = (mode_s2 == MODE_RISE_OUT) ? dout_r : dout_f; // [R02] [R03]
	assign dout_oe = !cs_n; // [R04]

endmodule : spp_link

// ---- core/spp_link_if.sv ----
// Signals passed between the control logic and the serial-clock logic
`timescale 1ns/1ps
interface spp_link_if;
	import spp_pkg::*;

	logic [7:0] rx_byte;
	logic [1:0] rx_index;
	logic rx_toggle;
	logic [1:0] clk_mode;
	logic [TX_BITS-1:0] tx_word;

	modport link (output rx_byte, output rx_index, output rx_toggle,
		input clk_mode, input tx_word);
	modport core (input rx_byte, input rx_index, input rx_toggle,
		output clk_mode, output tx_word);
endinterface : spp_link_if

// ---- core/spp_pkg.sv ----
// Shared constants and types for the serial control port block
package spp_pkg;

	// ==========================================================
	// Clock and timing
	localparam int CLOCK_KHZ = 25000;
	localparam int CONV_TIME_NS = 9000;
	localparam int CONV_CYCLES = (CONV_TIME_NS * (CLOCK_KHZ / 1000)) / 1000;
	localparam logic [8:0] CONV_CYCLES_W = 9'(CONV_CYCLES);

	// ==========================================================
	// Frame layout
	localparam int CMD_BITS = 8;
	localparam logic [4:0] FRAME_CNT_MAX = 5'h1f;
	localparam logic [4:0] TX_FIRST_FALL = 5'h07;
	localparam logic [4:0] TX_LAST_FALL = 5'h16;
	localparam logic [4:0] TX_FIRST_RISE = 5'h08;
	localparam logic [4:0] TX_LAST_RISE = 5'h17;
	localparam int TX_BITS = 16;

	// ==========================================================
	// Command byte fields
	localparam int CMD_CONV_BIT = 7;
	localparam logic [1:0] CMD_SETUP_TAG = 2'h1;
	localparam logic [3:0] CMD_DAC_TAG = 4'h1;
	localparam int SETUP_MODE_LSB = 4;
	localparam int SETUP_PIN_BIT = 3;
	localparam int DAC_CHAN_LSB = 4;

	// ==========================================================
	// Modes and reset values
	localparam logic [1:0] MODE_RISE_OUT = 2'h3;
	localparam logic [1:0] CLK_MODE_RST = 2'h0;
	localparam logic START_PIN_RST = 1'b0;

	typedef enum {CONV_IDLE, CONV_BUSY} spp_conv_t;

endpackage : spp_pkg

// ---- core/spp_top.sv ----
// Serial control port of the converter: command decode, conversion, DAC load
`timescale 1ns/1ps
// Overview of operation
// [R01] Input data is sampled on each falling serial clock edge while selected.
// [R02] In clock modes 00, 01, 10 output data changes on falling edges.
// [R03] In clock mode 11 output data changes on rising edges.
// [R04] The data output is high impedance while chip select is high.
// [R05] Master selects with chip select low; port reacts only while low.
// [R06] Active-low end-of-conversion output; result valid only after it falls.
// [R07] Active-low DAC load keeps DAC registers transparent while held low.
// [R08] Wake select pin picks DAC power-up pull: low ground, high reference.
// [R09] Setup byte chooses whether the shared pin acts as conversion start.
// [R10] Frames begin with an eight-bit command byte, MSB first, select held.
// [R11] Master uses equal clock polarity and phase settings.
// [R12] Deselect mid-transfer returns the shifter to idle, dropping partial bytes.
module spp_top
	import spp_pkg::*;
#(
	parameter int DAC_CHANNELS = 8,
	parameter int DATA_BITS = 12
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Serial link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	output logic dout,
	output logic dout_oe,
	// Conversion
	input wire logic convert_start_n,
	input wire logic [DATA_BITS-1:0] adc_sample,
	output logic eoc_n,
	output logic start_pin_enabled,
	// DAC
	input wire logic dac_load_n,
	input wire logic dac_wake_select,
	output logic [DAC_CHANNELS*DATA_BITS-1:0] dac_codes,
	output logic dac_pull_ref,
	output logic dac_powered
);

	// Elaboration refuses sizes the byte packing and channel field cannot serve
	if (DATA_BITS != 12 || DAC_CHANNELS < 1 || DAC_CHANNELS > 8) begin : g_param_check
		$error("spp_top: unsupported DATA_BITS or DAC_CHANNELS");
	end

	// ==========================================================
	// Serial-clock logic
	spp_link_if lnk ();

	spp_link u_link (
		.rst_n(rst_n),
		.sclk(sclk),
		.cs_n(cs_n),
		.din(din),
		.dout(dout),
		.dout_oe(dout_oe),
		.lnk(lnk.link)
	);

	// ==========================================================
	// Synchronisers for pins and the byte toggle
	logic tog_s1, tog_s2, tog_s3;
	logic load_s1, load_s2;
	logic wake_s1, wake_s2;
	logic start_s1, start_s2, start_s3;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			tog_s1 <= 1'b0;
			tog_s2 <= 1'b0;
			tog_s3 <= 1'b0;
			load_s1 <= 1'b1;
			load_s2 <= 1'b1;
			wake_s1 <= 1'b1;
			wake_s2 <= 1'b1;
			start_s1 <= 1'b1;
			start_s2 <= 1'b1;
			start_s3 <= 1'b1;
		end else begin
			tog_s1 <= lnk.rx_toggle;
			tog_s2 <= tog_s1;
			tog_s3 <= tog_s2;
			load_s1 <= dac_load_n;
			load_s2 <= load_s1;
			wake_s1 <= dac_wake_select;
			wake_s2 <= wake_s1;
			start_s1 <= convert_start_n;
			start_s2 <= start_s1;
			start_s3 <= start_s2;
		end
	end

	// ==========================================================
	// Control state
	logic [7:0] cur_cmd, next_cur_cmd;
	logic [7:0] dac_hi, next_dac_hi;
	logic [1:0] clk_mode, next_clk_mode;
	logic start_en, next_start_en;
	spp_conv_t conv, next_conv;
	logic [8:0] conv_cnt, next_conv_cnt;
	logic next_eoc_n;
	logic [DATA_BITS-1:0] result, next_result;
	logic [DATA_BITS-1:0] dac_in [DAC_CHANNELS];
	logic [DATA_BITS-1:0] next_dac_in [DAC_CHANNELS];
	logic [DATA_BITS-1:0] dac_out [DAC_CHANNELS];
	logic [DATA_BITS-1:0] next_dac_out [DAC_CHANNELS];
	logic next_pull_ref, next_powered;
	logic byte_new, start_req;
	logic [2:0] chan;

	assign byte_new = tog_s2 != tog_s3;
	assign chan = dac_hi[DAC_CHAN_LSB +: 3];

	always_comb begin
		next_cur_cmd = cur_cmd;
		next_dac_hi = dac_hi;
		next_clk_mode = clk_mode;
		next_start_en = start_en;
		next_dac_in = dac_in;
		next_dac_out = dac_out;
		start_req = start_en && !start_s2 && start_s3; // [R09]
		if (byte_new) begin
			case (lnk.rx_index)
				2'h0: begin
					next_cur_cmd = lnk.rx_byte; // [R10]
					if (lnk.rx_byte[CMD_CONV_BIT]) begin
						start_req = 1'b1;
					end else if (lnk.rx_byte[7:6] == CMD_SETUP_TAG) begin
						next_clk_mode = lnk.rx_byte[SETUP_MODE_LSB +: 2];
						next_start_en = lnk.rx_byte[SETUP_PIN_BIT]; // [R09]
					end
				end
				2'h1: begin
					if (cur_cmd[7:4] == CMD_DAC_TAG) begin
						next_dac_hi = lnk.rx_byte;
					end
				end
				2'h2: begin
					if (cur_cmd[7:4] == CMD_DAC_TAG && int'(chan) < DAC_CHANNELS) begin
						next_dac_in[chan] = {dac_hi[3:0], lnk.rx_byte};
					end
				end
				default: begin
				end
			endcase
		end
		if (!load_s2) begin
			next_dac_out = next_dac_in; // [R07]
		end
		next_powered = dac_powered || !load_s2;
		next_pull_ref = dac_powered ? dac_pull_ref : wake_s2; // [R08]

		next_conv = conv;
		next_conv_cnt = conv_cnt;
		next_eoc_n = eoc_n;
		next_result = result;
		case (conv)
			CONV_IDLE: begin
				if (start_req) begin
					next_conv = CONV_BUSY;
					next_conv_cnt = CONV_CYCLES_W;
					next_eoc_n = 1'b1;
				end
			end
			CONV_BUSY: begin
				next_conv_cnt = 9'(conv_cnt - 9'h001);
				if (conv_cnt == 9'h001) begin
					next_conv = CONV_IDLE;
					next_result = adc_sample;
					next_eoc_n = 1'b0; // [R06]
				end
			end
			default: begin
				next_conv = CONV_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cur_cmd <= 8'h00;
			dac_hi <= 8'h00;
			clk_mode <= CLK_MODE_RST;
			start_en <= START_PIN_RST;
			conv <= CONV_IDLE;
			conv_cnt <= 9'h000;
			eoc_n <= 1'b1;
			result <= '0;
			dac_pull_ref <= 1'b1;
			dac_powered <= 1'b0;
			for (int i = 0; i < DAC_CHANNELS; i++) begin
				dac_in[i] <= '0;
				dac_out[i] <= '0;
			end
		end else begin
			cur_cmd <= next_cur_cmd;
			dac_hi <= next_dac_hi;
			clk_mode <= next_clk_mode;
			start_en <= next_start_en;
			conv <= next_conv;
			conv_cnt <= next_conv_cnt;
			eoc_n <= next_eoc_n;
			result <= next_result;
			dac_pull_ref <= next_pull_ref;
			dac_powered <= next_powered;
			dac_in <= next_dac_in;
			dac_out <= next_dac_out;
		end
	end

	// ==========================================================
	// Outputs and values held for the serial-clock side
	always_comb begin
		for (int i = 0; i < DAC_CHANNELS; i++) begin
			dac_codes[i*DATA_BITS +: DATA_BITS] = dac_out[i];
		end
	end

	assign start_pin_enabled = start_en;
	assign lnk.clk_mode = clk_mode;
	// Result is only read after end of conversion falls, so it is static then
	assign lnk.tx_word = {{(TX_BITS-DATA_BITS){1'b0}}, result};

endmodule : spp_top
